/* verilog/bcr_regs.svh */
// Register offsets, field positions, reset values and counts of the bus configuration pair.
`ifndef BCR_REGS_SVH
`define BCR_REGS_SVH
`define BCR_OFF_RUNTIME    8'h00
`define BCR_OFF_PERSIST    8'h04
`define BCR_OFF_ERASE      8'h08
`define BCR_OFF_STATUS     8'h0c
`define BCR_OFF_EFFECTIVE  8'h10
`define BCR_OFF_SWRESET    8'h14
`define BCR_BIT_RSV_HI     15
`define BCR_DRV_HI         14
`define BCR_DRV_LO         12
`define BCR_BIT_LOCK       11
`define BCR_BIT_SECURE     10
`define BCR_MAP_HI         9
`define BCR_MAP_LO         8
`define BCR_LAT_HI         7
`define BCR_LAT_LO         4
`define BCR_BIT_RSV_LO     3
`define BCR_BIT_STALL      2
`define BCR_LEN_HI         1
`define BCR_LEN_LO         0
`define BCR_FACTORY        16'h8ebb
`define BCR_ERASED         16'hffff
`define BCR_LAT_BASE       5'h05
`define BCR_MASK_16B       32'h0000_0007
`define BCR_MASK_32B       32'h0000_000f
`define BCR_MASK_64B       32'h0000_001f
`endif

/* verilog/bcr_pkg.sv */
// Types shared by the bus configuration pair.
package bcr_pkg;
    typedef logic [15:0] bcr_word_t;
    typedef enum logic [1:0] {
        BCR_LEN_RSV = 2'h0,
        BCR_LEN_64  = 2'h1,
        BCR_LEN_16  = 2'h2,
        BCR_LEN_32  = 2'h3
    } bcr_len_t;
    typedef enum logic [1:0] {
        BCR_IDLE  = 2'h1,
        BCR_BURST = 2'h2
    } bcr_state_t;
endpackage

/* verilog/bcr_config_pair.sv */
// Nonvolatile and volatile bus configuration registers with source select and burst addressing.
//
// Decided for this implementation: the register addresses and the plain strobed port.
`include "bcr_regs.svh"

module bcr_config_pair (
    input  wire logic             clock,
    input  wire logic             rst,
    input  wire logic             ce,
    input  wire logic             nv_blank,
    input  wire logic [7:0]       addr,
    input  wire logic [15:0]      wdata,
    input  wire logic             wr,
    input  wire logic             rd,
    output logic      [15:0]      rdata,
    input  wire logic             link_clk,
    input  wire logic             link_cs_n,
    input  wire logic             burst_start,
    input  wire logic             burst_linear,
    input  wire logic [31:0]      burst_addr,
    input  wire logic             dual_error,
    input  wire logic             secure_prog_req,
    output logic      [31:0]      word_addr,
    output logic                  strobe_stall,
    output logic                  secure_prog_refused,
    output logic      [4:0]       latency_clocks,
    output bcr_pkg::bcr_len_t     burst_len,
    output logic      [2:0]       drive_strength,
    output logic      [1:0]       sector_map,
    output logic                  config_locked
);
    import bcr_pkg::*;

    bcr_word_t  persist_q;
    bcr_word_t  boot_q;
    bcr_word_t  runtime_q;
    bcr_word_t  effective_q;
    logic       source_q;
    logic       loaded_q;
    logic [2:0] clk_sync_q;
    logic [1:0] cs_sync_q;
    bcr_state_t state_q;
    logic [31:0] addr_q;
    logic [31:0] wrap_mask;
    logic       stall_q;
    logic       refused_q;
    logic [15:0] rdata_q;
    logic       idle;
    logic       unlocked;
    logic       load_ok;
    logic       prog_ok;
    logic       erase_ok;
    logic       link_rise;

    // Link pins come from another clock; logic reads the second select stage and the second and third clock stages.
    always_ff @(posedge clock) begin
        if (rst) begin
            clk_sync_q <= 3'h0;
            cs_sync_q  <= 2'h3;
        end else if (ce) begin
            clk_sync_q <= {clk_sync_q[1:0], link_clk};
            cs_sync_q  <= {cs_sync_q[0], link_cs_n};
        end
    end

    assign link_rise = clk_sync_q[1] & ~clk_sync_q[2];
    assign idle      = cs_sync_q[1] & (state_q == BCR_IDLE);
    // The runtime lock bit alone decides; after reset it already carries the persistent lock.
    assign unlocked  = runtime_q[`BCR_BIT_LOCK];
    assign load_ok   = ce & wr & (addr == `BCR_OFF_RUNTIME) & unlocked & idle;
    assign prog_ok   = ce & wr & (addr == `BCR_OFF_PERSIST) & unlocked;
    assign erase_ok  = ce & wr & (addr == `BCR_OFF_ERASE) & unlocked;

    // The persistent register is not touched by rst: it models nonvolatile cells.
    always_ff @(posedge clock) begin
        if (nv_blank) begin
            persist_q <= `BCR_FACTORY;
        end else if (prog_ok) begin
            persist_q <= persist_q & wdata;  // Flash programming only clears bits.
        end else if (erase_ok) begin
            persist_q <= `BCR_ERASED;
        end
    end

    // Boot copy freezes what the bus follows until the first runtime load or the next reset.
    always_ff @(posedge clock) begin
        if (rst) begin
            boot_q <= persist_q;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            runtime_q <= persist_q;
        end else if (ce) begin
            if (load_ok) begin
                runtime_q <= wdata;
            end else if (prog_ok && !loaded_q) begin
                // Lock bit kept so the unlocked-until-reset state can exist.
                runtime_q <= {persist_q[15:12] & wdata[15:12], runtime_q[`BCR_BIT_LOCK],
                              persist_q[10:0] & wdata[10:0]};
            end
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            source_q <= 1'b0;
            loaded_q <= 1'b0;
        end else if (load_ok) begin
            source_q <= 1'b1;
            loaded_q <= 1'b1;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            effective_q <= `BCR_FACTORY;
        end else if (ce) begin
            effective_q <= source_q ? runtime_q : boot_q;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            latency_clocks <= 5'h10;
            burst_len      <= BCR_LEN_32;
            drive_strength <= 3'h0;
            sector_map     <= 2'h2;
            config_locked  <= 1'b0;
        end else if (ce) begin
            latency_clocks <= {1'b0, effective_q[`BCR_LAT_HI:`BCR_LAT_LO]} + `BCR_LAT_BASE;
            burst_len      <= bcr_len_t'(effective_q[`BCR_LEN_HI:`BCR_LEN_LO]);
            drive_strength <= effective_q[`BCR_DRV_HI:`BCR_DRV_LO];
            sector_map     <= effective_q[`BCR_MAP_HI:`BCR_MAP_LO];
            config_locked  <= ~runtime_q[`BCR_BIT_LOCK];
        end
    end

    always_comb begin
        case (bcr_len_t'(effective_q[`BCR_LEN_HI:`BCR_LEN_LO]))
            BCR_LEN_16: wrap_mask = `BCR_MASK_16B;
            BCR_LEN_32: wrap_mask = `BCR_MASK_32B;
            BCR_LEN_64: wrap_mask = `BCR_MASK_64B;
            default:    wrap_mask = 32'h0000_0000;
        endcase
    end

    // One 16-bit word per link clock; a wrapped burst at the reserved length holds its address.
    always_ff @(posedge clock) begin
        if (rst) begin
            state_q <= BCR_IDLE;
            addr_q  <= 32'h0000_0000;
        end else if (ce) begin
            case (state_q)
                BCR_IDLE: begin
                    if (burst_start) begin
                        state_q <= BCR_BURST;
                        addr_q  <= burst_linear ? burst_addr : (burst_addr | 32'h8000_0000);
                    end
                end
                BCR_BURST: begin
                    if (cs_sync_q[1]) begin
                        state_q <= BCR_IDLE;
                    end else if (link_rise) begin
                        if (addr_q[31]) begin
                            addr_q <= 32'h8000_0000 | (addr_q & ~wrap_mask & 32'h7fff_ffff)
                                      | ((addr_q + 32'h1) & wrap_mask);
                        end else begin
                            addr_q <= addr_q + 32'h1;
                        end
                    end
                end
                default: state_q <= BCR_IDLE;
            endcase
        end
    end

    assign word_addr = {1'b0, addr_q[30:0]};

    // A double-bit error in a burst with stall bit 2 clear holds the strobe low until the burst ends or the software reset offset is written.
    always_ff @(posedge clock) begin
        if (rst) begin
            stall_q <= 1'b0;
        end else if (ce) begin
            if (wr && addr == `BCR_OFF_SWRESET) begin
                stall_q <= 1'b0;
            end else if (dual_error && !effective_q[`BCR_BIT_STALL] && state_q == BCR_BURST) begin
                stall_q <= 1'b1;
            end else if (state_q == BCR_IDLE) begin
                stall_q <= 1'b0;
            end
        end
    end

    assign strobe_stall = stall_q;

    always_ff @(posedge clock) begin
        if (rst) begin
            refused_q <= 1'b0;
        end else if (ce) begin
            refused_q <= secure_prog_req & ~effective_q[`BCR_BIT_SECURE];
        end
    end

    assign secure_prog_refused = refused_q;

    always_ff @(posedge clock) begin
        if (rst) begin
            rdata_q <= 16'h0000;
        end else if (ce) begin
            if (rd) begin
                case (addr)
                    `BCR_OFF_RUNTIME:   rdata_q <= runtime_q;
                    `BCR_OFF_PERSIST:   rdata_q <= persist_q;
                    `BCR_OFF_ERASE:     rdata_q <= boot_q;
                    `BCR_OFF_STATUS:    rdata_q <= {12'h000, idle, unlocked, loaded_q, source_q};
                    `BCR_OFF_EFFECTIVE: rdata_q <= effective_q;
                    default:            rdata_q <= 16'h0000;
                endcase
            end else begin
                rdata_q <= 16'h0000;
            end
        end
    end

    assign rdata = rdata_q;

    // All checks run on the system clock and see sampled values.
    // They stay silent while reset is held or the clock enable is low,
    // because the frozen state would otherwise look like a broken update.
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst || !ce);

    // Source selection and its behaviour around reset.
    a_boot_source: assert property ($fell(rst)
        |-> !source_q && !loaded_q)
        else $error("source not persistent after reset");

    a_load_selects: assert property (load_ok
        |=> source_q ##1 effective_q == $past(wdata, 2))
        else $error("runtime load not applied");

    a_source_sticky: assert property (source_q
        |=> source_q)
        else $error("source select dropped without reset");

    a_sw_keep: assert property (wr && addr == `BCR_OFF_SWRESET
        |=> source_q == $past(source_q))
        else $error("software reset moved the source select");

    // Lock handling; the runtime lock bit gates every runtime, persistent and erase write.
    a_lock_refuse: assert property (wr && !unlocked
        |=> $stable(runtime_q) && $stable(persist_q))
        else $error("locked register changed");

    a_perm_lock: assert property ($fell(rst) && !persist_q[11]
        |-> !runtime_q[11])
        else $error("permanent lock not applied");

    a_busy_refuse: assert property (wr && addr == `BCR_OFF_RUNTIME && !idle
        |=> $stable(runtime_q))
        else $error("runtime changed while busy");

    a_lock_follow: assert property (1'b1
        |=> config_locked == ~$past(runtime_q[`BCR_BIT_LOCK]))
        else $error("lock flag does not follow runtime lock");

    // Persistent program and erase.
    a_nv_no_effect: assert property (prog_ok && !source_q && !load_ok
        |=> ##1 effective_q == boot_q)
        else $error("persistent program changed behaviour");

    a_copy_unloaded: assert property (prog_ok && !loaded_q
        |=> runtime_q[10:0] == ($past(persist_q[10:0]) & $past(wdata[10:0])))
        else $error("unloaded runtime not copied");

    a_loaded_kept: assert property ((prog_ok || erase_ok) && loaded_q
        |=> $stable(runtime_q))
        else $error("loaded runtime changed by persistent write");

    a_nv_program: assert property (prog_ok && !nv_blank
        |=> persist_q == ($past(persist_q) & $past(wdata)))
        else $error("persistent program did not clear bits");

    a_nv_erase: assert property (erase_ok && !nv_blank
        |=> persist_q == `BCR_ERASED)
        else $error("persistent erase did not set all bits");

    // Decoded bus settings follow the effective word one edge later.
    a_latency_map: assert property (1'b1
        |=> latency_clocks == $past(effective_q[7:4]) + 5'h05)
        else $error("latency code wrong");

    a_len_map: assert property (1'b1
        |=> burst_len == $past(effective_q[`BCR_LEN_HI:`BCR_LEN_LO]))
        else $error("burst length code wrong");

    a_drive_map: assert property (1'b1
        |=> drive_strength == $past(effective_q[`BCR_DRV_HI:`BCR_DRV_LO]))
        else $error("drive strength code wrong");

    a_sector_map: assert property (1'b1
        |=> sector_map == $past(effective_q[`BCR_MAP_HI:`BCR_MAP_LO]))
        else $error("sector map code wrong");

    a_secure_refuse: assert property (secure_prog_req && !effective_q[`BCR_BIT_SECURE]
        |=> secure_prog_refused)
        else $error("secure program not refused");

    a_secure_allow: assert property (!(secure_prog_req && !effective_q[`BCR_BIT_SECURE])
        |=> !secure_prog_refused)
        else $error("secure program refused without cause");

    // Burst addressing and the strobe stall.
    a_wrap_group: assert property (state_q == BCR_BURST && link_rise && !cs_sync_q[1] && addr_q[31]
        |=> (word_addr & ~wrap_mask) == ($past(word_addr) & ~$past(wrap_mask)))
        else $error("wrap left its group");

    a_linear_step: assert property (state_q == BCR_BURST && link_rise && !cs_sync_q[1] && !addr_q[31]
        |=> word_addr == $past(word_addr) + 32'h1)
        else $error("linear burst did not step by one");

    a_stall_hold: assert property (stall_q && state_q == BCR_BURST && !(wr && addr == 8'h14)
        |=> stall_q)
        else $error("stall released mid burst");

    a_stall_set: assert property (dual_error && !effective_q[`BCR_BIT_STALL] && state_q == BCR_BURST
        && !(wr && addr == `BCR_OFF_SWRESET) |=> stall_q)
        else $error("stall not raised on double error");

    a_no_stall: assert property (!stall_q
        && !(dual_error && !effective_q[`BCR_BIT_STALL] && state_q == BCR_BURST) |=> !stall_q)
        else $error("stall raised without cause");

    // Main scenarios that the bench is expected to reach.
    c_load: cover property (load_ok ##1 source_q);
    c_wrap16: cover property (state_q == BCR_BURST && wrap_mask == 32'h7 && link_rise);
    c_stall: cover property ($rose(stall_q));
    c_perm_lock: cover property ($fell(rst) && !persist_q[`BCR_BIT_LOCK]);
    c_busy_write: cover property (wr && addr == `BCR_OFF_RUNTIME && !idle);
endmodule // bcr_config_pair

/* sim/bcr_host_model.sv */
// Behavioural host bus controller that runs bursts over the link and records the word addresses.
module bcr_host_model (
    input  wire logic        clock,
    input  wire logic [31:0] word_addr,
    output logic             link_clk,
    output logic             link_cs_n,
    output logic             burst_start,
    output logic             burst_linear,
    output logic [31:0]      burst_addr
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [31:0] seen [$];
    initial begin
        link_clk = 1'b0;
        link_cs_n = 1'b1;
        burst_start = 1'b0;
        burst_linear = 1'b0;
        burst_addr = 32'h0000_0000;
    end
    // The link clock only toggles inside a frame; each address is sampled just before the next rise, the last one just before the select rises.
    task automatic run(input logic [31:0] start, input logic lin, input int n);
        seen.delete();
        // Select goes low first so the synchronised select is low when the burst starts.
        @(posedge clock);
        link_cs_n <= 1'b0;
        repeat (3) @(posedge clock);
        burst_start <= 1'b1;
        burst_linear <= lin;
        burst_addr <= start;
        @(posedge clock);
        burst_start <= 1'b0;
        burst_linear <= ~lin;
        burst_addr <= ~start;
        #110;
        for (int i = 0; i <= n; i++) begin
            seen.push_back(word_addr);
            if (i < n) begin
                link_clk = 1'b1;
                #100;
                link_clk = 1'b0;
                #100;
            end
        end
        link_cs_n = 1'b1;
        repeat (5) @(posedge clock);
    endtask
endmodule // bcr_host_model

/* sim/tb_bus_config_register_pair.sv */
// Self-checking bench for the bus configuration register pair.
module tb_bus_config_register_pair;
    timeunit 1ns;
    timeprecision 1ps;
    import bcr_pkg::*;
    typedef struct packed {
        logic [15:0] cfg;
        logic [4:0]  lat;
        logic [1:0]  len;
        logic [2:0]  drv;
        logic [1:0]  map;
    } bcr_row_t;
    logic        clock, rst, ce, nv_blank, wr, rd, dual_error, secure_prog_req;
    logic [7:0]  addr;
    logic [15:0] wdata, rdata, rdv;
    logic        link_clk, link_cs_n, burst_start, burst_linear, strobe_stall, secure_prog_refused, config_locked;
    logic [31:0] burst_addr, word_addr, e;
    logic [4:0]  latency_clocks;
    bcr_len_t    burst_len;
    logic [2:0]  drive_strength;
    logic [1:0]  sector_map;
    int          n_errors = 0;
    int          n_tests = 0;
    bcr_row_t    rows [5] = '{'{16'h9c0e, 5'h05, 2'h2, 3'h1, 2'h0}, '{16'ha91d, 5'h06, 2'h1, 3'h2, 2'h1},
                              '{16'hbabf, 5'h10, 2'h3, 3'h3, 2'h2}, '{16'hcbf8, 5'h14, 2'h0, 3'h4, 2'h3},
                              '{16'hfc4c, 5'h09, 2'h0, 3'h7, 2'h0}};

    bcr_config_pair bcr_config_pair_i (.clock(clock), .rst(rst), .ce(ce), .nv_blank(nv_blank), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .link_clk(link_clk), .link_cs_n(link_cs_n),
        .burst_start(burst_start), .burst_linear(burst_linear), .burst_addr(burst_addr), .dual_error(dual_error),
        .secure_prog_req(secure_prog_req), .word_addr(word_addr), .strobe_stall(strobe_stall),
        .secure_prog_refused(secure_prog_refused), .latency_clocks(latency_clocks), .burst_len(burst_len),
        .drive_strength(drive_strength), .sector_map(sector_map), .config_locked(config_locked));
    bcr_host_model bcr_host_model_i (.clock(clock), .word_addr(word_addr), .link_clk(link_clk),
        .link_cs_n(link_cs_n), .burst_start(burst_start), .burst_linear(burst_linear), .burst_addr(burst_addr));

    initial begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
        @(posedge clock);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clock);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [7:0] a);
        @(posedge clock);
        rd <= 1'b1;
        addr <= a;
        @(posedge clock);
        rd <= 1'b0;
        #1 rdv = rdata;
    endtask
    task automatic settle();
        repeat (4) @(posedge clock);
        #1;
    endtask
    task automatic hw_reset(input logic blank);
        @(posedge clock);
        rst <= 1'b1;
        nv_blank <= blank;
        repeat (12) @(posedge clock);
        rst <= 1'b0;
        nv_blank <= 1'b0;
        settle();
    endtask
    // A double-bit error is injected mid-burst so the stall bit and the wrap sequence are seen together.
    task automatic burst(input logic [15:0] cfg, input logic [31:0] st, input logic lin, input logic [31:0] m);
        wr_reg(8'h00, cfg);
        settle();
        fork
            bcr_host_model_i.run(st, lin, 8);
            begin
                repeat (12) @(posedge clock);
                dual_error <= 1'b1;
                @(posedge clock);
                dual_error <= 1'b0;
                settle();
                chk("strobe_stall", 32'(!cfg[2]), 32'(strobe_stall));
                wr_reg(8'h00, 16'h9c0e);
            end
        join
        rd_reg(8'h00);
        chk("runtime busy", 32'(cfg), 32'(rdv));
        e = st;
        foreach (bcr_host_model_i.seen[i]) begin
            chk("word_addr", e, bcr_host_model_i.seen[i]);
            e = lin ? e + 32'h1 : (e & ~m) | ((e + 32'h1) & m);
        end
    endtask

    initial begin
        rst = 1'b1;
        ce = 1'b1;
        nv_blank = 1'b1;
        {wr, rd, dual_error, secure_prog_req} = 4'h0;
        addr = 8'h00;
        wdata = 16'h0000;
        hw_reset(1'b1);
        rd_reg(8'h04);
        chk("persistent", 32'h8ebb, 32'(rdv));
        rd_reg(8'h10);
        chk("effective", 32'h8ebb, 32'(rdv));
        chk("drive", 32'h0, 32'(drive_strength));
        rd_reg(8'h0c);
        chk("source", 32'h0, 32'(rdv[0]));
        wr_reg(8'h04, 16'hffdf);
        rd_reg(8'h00);
        chk("runtime copy", 32'h8e9b, 32'(rdv));
        chk("latency", 32'h10, 32'(latency_clocks));
        foreach (rows[i]) begin
            wr_reg(8'h00, rows[i].cfg);
            settle();
            chk("latency", 32'(rows[i].lat), 32'(latency_clocks));
            chk("burst_len", 32'(rows[i].len), 32'(burst_len));
            chk("drive", 32'(rows[i].drv), 32'(drive_strength));
            chk("map", 32'(rows[i].map), 32'(sector_map));
            rd_reg(8'h10);
            chk("effective", 32'(rows[i].cfg), 32'(rdv));
        end
        rd_reg(8'h0c);
        chk("source", 32'h1, 32'(rdv[0]));
        wr_reg(8'h08, 16'h0000);
        rd_reg(8'h00);
        chk("runtime", 32'hfc4c, 32'(rdv));
        chk("latency", 32'h09, 32'(latency_clocks));
        wr_reg(8'h14, 16'h0001);
        rd_reg(8'h0c);
        chk("source", 32'h1, 32'(rdv[0]));
        for (int k = 0; k < 2; k++) begin
            wr_reg(8'h00, (k != 0) ? 16'h8ebb : 16'h8abb);
            settle();
            @(posedge clock);
            secure_prog_req <= 1'b1;
            @(posedge clock);
            secure_prog_req <= 1'b0;
            #1 chk("refused", 32'(k == 0), 32'(secure_prog_refused));
        end
        ce <= 1'b0;
        wr_reg(8'h00, 16'h9c0e);
        ce <= 1'b1;
        rd_reg(8'h00);
        chk("frozen", 32'h8ebb, 32'(rdv));
        burst(16'h8eba, 32'h02, 1'b0, 32'h07);
        burst(16'h8ebf, 32'h1e, 1'b0, 32'h0f);
        burst(16'h8ebd, 32'h2e, 1'b0, 32'h1f);
        burst(16'h8ebb, 32'h03, 1'b1, 32'h07);
        hw_reset(1'b0);
        rd_reg(8'h0c);
        chk("source", 32'h0, 32'(rdv[0]));
        chk("latency", 32'h14, 32'(latency_clocks));
        wr_reg(8'h04, 16'hf7ff);
        wr_reg(8'h00, 16'hfebb);
        rd_reg(8'h00);
        chk("runtime", 32'hfebb, 32'(rdv));
        hw_reset(1'b0);
        chk("locked", 32'h1, 32'(config_locked));
        wr_reg(8'h00, 16'hffff);
        wr_reg(8'h04, 16'h0000);
        rd_reg(8'h00);
        chk("runtime", 32'hf7ff, 32'(rdv));
        rd_reg(8'h04);
        chk("persistent", 32'hf7ff, 32'(rdv));
        wrap_up();
    end
    initial begin
        #200000;
        n_errors++;
        wrap_up();
    end
endmodule // tb_bus_config_register_pair
